// file: srcd_pkg.sv
// Constants for the receive sync and special-character detect block.
// Assumes a single 32-bit AHB-Lite slave port, word accesses only.
package srcd_pkg;
    // Register byte offsets
    localparam logic [7:0] RX_STATUS_OFS = 8'h00;
    localparam logic [7:0] REG_PTR_OFS = 8'h04;
    localparam logic [7:0] SELECT6_OFS = 8'h08;
    localparam logic [7:0] CONTROL_OFS = 8'h0C;
    localparam logic [7:0] SYNC_CHAR_OFS = 8'h10;
    localparam logic [7:0] INT_STATUS_OFS = 8'h14;
    localparam logic [7:0] INT_MASK_OFS = 8'h18;
    // Receive status field positions
    localparam int CHAR_IE_BIT = 4;
    localparam int INDEX_LSB = 8;
    localparam int RX_ACTIVE_BIT = 12;
    localparam int USER_OPT_LSB = 13;
    localparam int CHAR_FLAG_BIT = 15;
    // Pointer register field and the character-detect code (octal 10)
    localparam int PTR_LSB = 8;
    localparam logic [3:0] PTR_CHAR_DETECT = 4'h8;
    // Control register bits
    localparam int CTL_RX_GO_BIT = 0;
    localparam int CTL_TWO_SYNC_BIT = 1;
    localparam int CTL_ACT_ON_DATA_BIT = 2;
    localparam int CTL_DOUBLE_BIT = 3;
    // Interrupt status bits
    localparam int INT_MATCH_BIT = 0;
    localparam int INT_ACTIVE_BIT = 1;
    // Values after reset
    localparam logic [3:0] CONTROL_RESET = 4'h6;
    localparam logic [7:0] SYNC_CHAR_RESET = 8'h96;
    localparam logic [1:0] INT_MASK_RESET = 2'h0;
    // Character geometry
    localparam int CHAR_BITS = 8;
    localparam int TABLE_DEPTH = 16;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // Receive sequencer states
    typedef enum logic [1:0] {HUNT, SYNC_ONE, SYNCED, ACTIVE} srcd_state_t;
endpackage : srcd_pkg

// file: srcd_receive.sv
// Receive synchronisation, special-character table and match logic.
// Assumes modem pins asynchronous to sys_clk; AHB-Lite single slave.
`timescale 1ns/1ps
// How it works
// - With pointer at octal 10, select-six word reads or writes the indexed one of sixteen entries.
// - Index bits writable only when idle and option present; reset zero.
// - Bit 12 shows receiver synchronised and in data transfer mode.
// - Sync gained after one or two consecutive sync characters.
// - Active set at sync, or on first non-sync character after.
// - Reset default: two syncs, active on first non-sync character.
// - Bits 13 and 14 are plain read/write storage, reset zero.
// - Match sets flag bit 15 and latches the matched index.
// - Flag with enable bit 4 set requests a character interrupt.
// - Double mode shifts in at high-byte MSB toward low-byte LSB.
// - Double mode flags only matches sitting in the high byte.
module srcd_receive #(
    parameter bit CHAR_RECOG_PRESENT = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Modem side
    input wire logic rxSerialData,
    input wire logic rxSerialClk,
    // Transmit side status
    input wire logic txActive,
    // Received data and state
    output logic [15:0] rxWord,
    output logic rxWordValid,
    output logic syncStateOne,
    output logic syncStateTwo,
    // Interrupts
    output logic charIrq,
    output logic irq
);
    import srcd_pkg::*;

    logic [15:0] table_q [TABLE_DEPTH];
    logic [3:0] index_q;
    logic [3:0] ptr_q;
    logic rxActive_q;
    logic [1:0] userOpt_q;
    logic charFlag_q;
    logic charIe_q;
    logic [3:0] control_q;
    logic [7:0] syncChar_q;
    logic [1:0] intStatus_q;
    logic [1:0] intMask_q;
    srcd_state_t state_q;
    logic [15:0] shift_q;
    logic [2:0] bitCnt_q;
    logic slot_q;
    logic [2:0] datSync_q;
    logic [2:0] clkSync_q;
    logic wrPend_q;
    logic rdPend_q;
    logic [7:0] addr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic [15:0] rxWord_q;
    logic rxWordValid_q;
    logic charIrq_q;
    logic irq_q;
    logic accept;
    logic wrStatus;
    logic wrSelect6;
    logic ptrOk;
    logic bitTick;
    logic [15:0] shiftNext;
    logic [7:0] newChar;
    logic charDone;
    logic isSync;
    logic matchHit;
    logic [3:0] matchIdx;
    logic matchEvent;
    logic activeSet;
    logic rxGo;
    logic dataChar;
    logic [31:0] readMux;
    assign rxGo = control_q[CTL_RX_GO_BIT];
    assign accept = hsel && htrans[1] && hready;
    assign wrStatus = wrPend_q && (addr_q == RX_STATUS_OFS);
    assign ptrOk = (ptr_q == PTR_CHAR_DETECT);
    assign wrSelect6 = wrPend_q && (addr_q == SELECT6_OFS) && ptrOk;

    // Bus phases
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            addr_q <= 8'h00;
            hreadyout_q <= 1'b1;
            hrdata_q <= 32'h00000000;
        end else begin
            wrPend_q <= accept && hwrite;
            rdPend_q <= accept && !hwrite;
            if (accept) begin
                addr_q <= {haddr[7:2], 2'b00};
            end
            if (accept && !hwrite) begin
                hreadyout_q <= 1'b0;
            end else if (rdPend_q) begin
                hreadyout_q <= 1'b1;
                hrdata_q <= readMux;
            end
        end
    end

    // Read decode, unmapped reads as zero
    always_comb begin
        readMux = 32'h00000000;
        unique case (addr_q)
            RX_STATUS_OFS: begin
                readMux[CHAR_FLAG_BIT] = charFlag_q;
                readMux[USER_OPT_LSB +: 2] = userOpt_q;
                readMux[RX_ACTIVE_BIT] = rxActive_q;
                readMux[INDEX_LSB +: 4] = index_q;
                readMux[CHAR_IE_BIT] = charIe_q;
            end
            REG_PTR_OFS: readMux[PTR_LSB +: 4] = ptr_q;
            SELECT6_OFS: if (ptrOk)
                readMux[15:0] = table_q[index_q];
            CONTROL_OFS: readMux[3:0] = control_q;
            SYNC_CHAR_OFS: readMux[7:0] = syncChar_q;
            INT_STATUS_OFS: readMux[1:0] = intStatus_q;
            INT_MASK_OFS: readMux[1:0] = intMask_q;
            default: readMux = 32'h00000000;
        endcase
    end

    // Software registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ptr_q <= 4'h0;
            userOpt_q <= 2'b00;
            charIe_q <= 1'b0;
            control_q <= CONTROL_RESET;
            syncChar_q <= SYNC_CHAR_RESET;
            intMask_q <= INT_MASK_RESET;
        end else if (wrPend_q) begin
            unique case (addr_q)
                RX_STATUS_OFS: begin
                    userOpt_q <= hwdata[USER_OPT_LSB +: 2];
                    charIe_q <= hwdata[CHAR_IE_BIT];
                end
                REG_PTR_OFS: ptr_q <= hwdata[PTR_LSB +: 4];
                CONTROL_OFS: control_q <= hwdata[3:0];
                SYNC_CHAR_OFS: syncChar_q <= hwdata[7:0];
                INT_MASK_OFS: intMask_q <= hwdata[1:0];
                default: ptr_q <= ptr_q;
            endcase
        end
    end

    // Secondary character table
    always_ff @(posedge sys_clk) begin
        if (wrSelect6) begin
            table_q[index_q] <= hwdata[15:0];
        end
    end

    // Index field: hardware latch on match beats a software write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            index_q <= 4'h0;
        end else if (matchEvent) begin
            index_q <= matchIdx;
        end else if (wrStatus && !rxActive_q && !txActive
                     && CHAR_RECOG_PRESENT) begin
            index_q <= hwdata[INDEX_LSB +: 4];
        end
    end

    // Modem pin synchronisers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            datSync_q <= 3'b000;
            clkSync_q <= 3'b000;
        end else begin
            datSync_q <= {datSync_q[1:0], rxSerialData};
            clkSync_q <= {clkSync_q[1:0], rxSerialClk};
        end
    end

    assign bitTick = clkSync_q[1] && !clkSync_q[2];
    assign shiftNext = {datSync_q[1], shift_q[15:1]};
    assign newChar = shiftNext[15:8];
    assign charDone = bitTick && (bitCnt_q == LAST_BIT);
    assign isSync = (newChar == syncChar_q);
    // Table compare, lowest index wins
    always_comb begin
        matchHit = 1'b0;
        matchIdx = 4'h0;
        for (int i = TABLE_DEPTH - 1; i >= 0; i--) begin
            if (table_q[i][CHAR_BITS-1:0] == newChar) begin
                matchHit = 1'b1;
                matchIdx = 4'(i);
            end
        end
    end
    // Data character: first non-sync once synced, then every one
    assign dataChar = charDone && ((state_q == ACTIVE)
        || ((state_q == SYNCED) && !isSync));
    // One compare per character; double mode only in high-byte slot
    assign matchEvent = CHAR_RECOG_PRESENT && dataChar && matchHit
        && (!control_q[CTL_DOUBLE_BIT] || slot_q);
    assign activeSet = !rxActive_q && (state_q == SYNCED)
        && (!control_q[CTL_ACT_ON_DATA_BIT] || dataChar);
    // Shifter and character framing
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            shift_q <= 16'h0000;
            bitCnt_q <= 3'h0;
            slot_q <= 1'b0;
        end else if (!rxGo) begin
            bitCnt_q <= 3'h0;
            slot_q <= 1'b0;
        end else if (bitTick) begin
            shift_q <= shiftNext;
            if (state_q == HUNT) begin
                bitCnt_q <= 3'h0;
                slot_q <= 1'b0;
            end else begin
                bitCnt_q <= bitCnt_q + 3'h1;
                slot_q <= slot_q ^ dataChar;
            end
        end
    end
    // Sync hunt sequencer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= HUNT;
        end else if (!rxGo) begin
            state_q <= HUNT;
        end else if (bitTick) begin
            unique case (state_q)
                HUNT: begin
                    if (isSync) begin
                        state_q <= control_q[CTL_TWO_SYNC_BIT]
                            ? SYNC_ONE : SYNCED;
                    end
                end
                SYNC_ONE: begin
                    if (charDone) begin
                        state_q <= isSync ? SYNCED : HUNT;
                    end
                end
                SYNCED: begin
                    if (charDone && !isSync) begin
                        state_q <= ACTIVE;
                    end
                end
                ACTIVE: state_q <= ACTIVE;
            endcase
        end
    end

    // Receive active and the sync state outputs
    always_ff @(posedge sys_clk) begin
        if (rst || !rxGo) begin
            rxActive_q <= 1'b0;
            syncStateOne <= 1'b0;
            syncStateTwo <= 1'b0;
        end else begin
            if (activeSet) begin
                rxActive_q <= 1'b1;
            end
            syncStateOne <= (state_q == SYNCED) || (state_q == ACTIVE);
            syncStateTwo <= (state_q == SYNCED) || (state_q == ACTIVE);
        end
    end

    // Received data word
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rxWord_q <= 16'h0000;
            rxWordValid_q <= 1'b0;
        end else begin
            rxWordValid_q <= 1'b0;
            if (dataChar && (!control_q[CTL_DOUBLE_BIT] || slot_q)) begin
                rxWord_q <= shiftNext;
                rxWordValid_q <= 1'b1;
            end
        end
    end
    // Character flag and sticky status, set beats clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            charFlag_q <= 1'b0;
            intStatus_q <= 2'b00;
        end else begin
            if (matchEvent) begin
                charFlag_q <= 1'b1;
            end else if (wrStatus && hwdata[CHAR_FLAG_BIT]) begin
                charFlag_q <= 1'b0;
            end
            for (int i = 0; i < 2; i++) begin
                if ((i == INT_MATCH_BIT) ? matchEvent : activeSet) begin
                    intStatus_q[i] <= 1'b1;
                end else if (wrPend_q && addr_q == INT_STATUS_OFS
                             && hwdata[i]) begin
                    intStatus_q[i] <= 1'b0;
                end
            end
        end
    end
    // Interrupt outputs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            charIrq_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            charIrq_q <= charFlag_q && charIe_q;
            irq_q <= |(intStatus_q & intMask_q);
        end
    end
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign rxWord = rxWord_q;
    assign rxWordValid = rxWordValid_q;
    assign charIrq = charIrq_q;
    assign irq = irq_q;
endmodule : srcd_receive

// file: srcd_receive_monitor.sv
// Port-level checks for the receive sync and character detect block.
// Assumes a bind to srcd_receive; one clock sys_clk, sync reset rst.
`timescale 1ns/1ps
module srcd_receive_monitor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Receive side
    input wire logic [15:0] rxWord,
    input wire logic rxWordValid,
    input wire logic syncStateOne,
    input wire logic syncStateTwo,
    input wire logic charIrq,
    input wire logic irq
);
    logic busTake;
    assign busTake = hsel && htrans[1] && hready;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not OKAY");
    chk_read_wait: assert property (
        busTake && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_write_ready: assert property (
        busTake && hwrite |=> hreadyout)
        else $error("write stalled");
    chk_wait_short: assert property (
        !hreadyout |=> hreadyout)
        else $error("wait state too long");
    chk_sync_pair: assert property (
        syncStateOne == syncStateTwo)
        else $error("sync states disagree");
    chk_valid_pulse: assert property (
        rxWordValid |=> !rxWordValid)
        else $error("word valid longer than a cycle");
    chk_word_hold: assert property (
        !$stable(rxWord) |-> rxWordValid)
        else $error("word changed without valid");
    chk_reset_quiet: assert property (
        $fell(rst) |-> hrdata == 32'h0 && hreadyout && !syncStateOne
        && !rxWordValid && !charIrq && !irq)
        else $error("outputs not cleared by reset");
    cov_read: cover property (busTake && !hwrite);
    cov_sync: cover property ($rose(syncStateOne));
    cov_char_irq: cover property ($rose(charIrq));
endmodule : srcd_receive_monitor
bind srcd_receive srcd_receive_monitor u_srcd_receive_monitor (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rxWord(rxWord),
    .rxWordValid(rxWordValid), .syncStateOne(syncStateOne),
    .syncStateTwo(syncStateTwo), .charIrq(charIrq), .irq(irq));

// file: srcd_modem_model.sv
// Modem model sending serial characters, LSB first.
// Assumes the caller enters send_byte just after a rising sys_clk.
`timescale 1ns/1ps
module srcd_modem_model (
    // Clock
    input wire logic sys_clk,
    // Serial line
    output logic rxSerialData,
    output logic rxSerialClk
);
    initial begin
        rxSerialData = 1'b0;
        rxSerialClk = 1'b0;
    end
    // Bit clock stands low between characters
    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            rxSerialData <= b[i];
            repeat (4) @(posedge sys_clk);
            rxSerialClk <= 1'b1;
            repeat (4) @(posedge sys_clk);
            rxSerialClk <= 1'b0;
        end
        rxSerialData <= ~b[7];
        repeat (8) @(posedge sys_clk);
    endtask : send_byte
endmodule : srcd_modem_model

// file: srcd_receive_tb.sv
// Self-checking bench for the receive sync and character detect block.
// Assumes srcd_pkg, srcd_receive and srcd_modem_model compiled first.
`timescale 1ns/1ps
module srcd_receive_tb;
    import srcd_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [2:0] hsize = 3'h0;
    logic txActive = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, rxSerialData, rxSerialClk;
    logic [15:0] rxWord;
    logic rxWordValid, syncStateOne, syncStateTwo, charIrq, irq;
    int errCount = 0;
    int nChecks = 0;
    int cycles = 0;
    always #25 sys_clk = ~sys_clk;
    srcd_receive u_srcd_receive (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rxSerialData(rxSerialData),
        .rxSerialClk(rxSerialClk), .txActive(txActive), .rxWord(rxWord),
        .rxWordValid(rxWordValid), .syncStateOne(syncStateOne),
        .syncStateTwo(syncStateTwo), .charIrq(charIrq), .irq(irq));
    srcd_modem_model u_srcd_modem_model (.sys_clk(sys_clk),
        .rxSerialData(rxSerialData), .rxSerialClk(rxSerialClk));
    task automatic tallyAndFinish();
        if (errCount == 0 && nChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tallyAndFinish
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errCount++;
            tallyAndFinish();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            errCount++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        hsize <= 3'h2;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, e);
    endtask : rd
    task automatic t_reset_values();
        rd(RX_STATUS_OFS, 32'h0);
        rd(CONTROL_OFS, 32'h6);
        rd(SYNC_CHAR_OFS, 32'h96);
        rd(INT_MASK_OFS, 32'h0);
        rd(8'h1C, 32'h0);
    endtask : t_reset_values
    task automatic t_status_bits();
        wr(RX_STATUS_OFS, 32'h6510);
        rd(RX_STATUS_OFS, 32'h6510);
        txActive <= 1'b1;
        wr(RX_STATUS_OFS, 32'h0310);
        rd(RX_STATUS_OFS, 32'h0510);
        txActive <= 1'b0;
    endtask : t_status_bits
    task automatic t_table();
        wr(SELECT6_OFS, 32'h1234);
        rd(SELECT6_OFS, 32'h0);
        wr(REG_PTR_OFS, 32'h0800);
        for (int k = 0; k < 16; k++) begin
            wr(RX_STATUS_OFS, 32'(k << 8));
            wr(SELECT6_OFS, (k == 3) ? 32'h41 : 32'(32 + k));
        end
        for (int k = 0; k < 16; k++) begin
            wr(RX_STATUS_OFS, 32'(k << 8));
            rd(SELECT6_OFS, (k == 3) ? 32'h41 : 32'(32 + k));
        end
    endtask : t_table
    task automatic t_sync_default();
        wr(INT_MASK_OFS, 32'h3);
        wr(RX_STATUS_OFS, 32'h0010);
        wr(CONTROL_OFS, 32'h7);
        u_srcd_modem_model.send_byte(8'h96);
        check(32'(syncStateOne), 32'h0);
        u_srcd_modem_model.send_byte(8'h96);
        check(32'({syncStateOne, syncStateTwo}), 32'h3);
        rd(RX_STATUS_OFS, 32'h0010);
        u_srcd_modem_model.send_byte(8'h41);
        rd(RX_STATUS_OFS, 32'h9310);
        check(32'({charIrq, irq}), 32'h3);
        rd(INT_STATUS_OFS, 32'h3);
        wr(RX_STATUS_OFS, 32'h8010);
        wr(INT_STATUS_OFS, 32'h3);
        repeat (2) @(posedge sys_clk);
        check(32'({charIrq, irq}), 32'h0);
    endtask : t_sync_default
    task automatic t_sync_single();
        wr(CONTROL_OFS, 32'h0);
        rd(RX_STATUS_OFS, 32'h0310);
        wr(CONTROL_OFS, 32'h1);
        u_srcd_modem_model.send_byte(8'h96);
        rd(RX_STATUS_OFS, 32'h1310);
        check(32'(syncStateOne), 32'h1);
    endtask : t_sync_single
    task automatic t_double();
        wr(CONTROL_OFS, 32'h0);
        wr(INT_STATUS_OFS, 32'h3);
        wr(CONTROL_OFS, 32'hF);
        u_srcd_modem_model.send_byte(8'h96);
        u_srcd_modem_model.send_byte(8'h96);
        u_srcd_modem_model.send_byte(8'h41);
        u_srcd_modem_model.send_byte(8'h00);
        check(32'(rxWord), 32'h0041);
        rd(RX_STATUS_OFS, 32'h1310);
        u_srcd_modem_model.send_byte(8'h00);
        u_srcd_modem_model.send_byte(8'h41);
        check(32'(rxWord), 32'h4100);
        rd(RX_STATUS_OFS, 32'h9310);
        wr(RX_STATUS_OFS, 32'h0000);
        repeat (2) @(posedge sys_clk);
        check(32'({charIrq, irq}), 32'h1);
    endtask : t_double
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_reset_values();
        t_status_bits();
        t_table();
        t_sync_default();
        t_sync_single();
        t_double();
        tallyAndFinish();
    end
endmodule : srcd_receive_tb
